// [hdl/sxe_map.svh]
`ifndef SXE_MAP_SVH
`define SXE_MAP_SVH
// data widths of the core
`define SXE_DATA_W 8
`define SXE_NIB_W 4
`define SXE_PROG_W 16
`define SXE_PADDR_W 13
`define SXE_DADDR_W 8
`define SXE_BIT_W 3
// reset values and the zero byte constant
`define SXE_ACC_RST 8'h00
`define SXE_TABLE_HIGH_BYTE_LATCH_RST 8'h00
`define SXE_ZERO_BYTE 8'h00
// last page high bits of the program address
`define SXE_LAST_PAGE 5'h1F
`define SXE_PAGE_W 5
// skip occupies two instruction cycles
`define SXE_SKIP_CYCLES 2
`endif

// [hdl/sxe_pkg.sv]
`default_nettype none
`include "sxe_map.svh"
package sxe_pkg;
	// operation selected by the instruction decoder
	typedef enum logic [3:0] {
		SXE_OP_NONE = 4'h0,
		SXE_OP_SWAP = 4'h1,
		SXE_OP_SWAP_ACC = 4'h2,
		SXE_OP_SKZ = 4'h3,
		SXE_OP_SKZ_MOVE = 4'h4,
		SXE_OP_SKZ_BIT = 4'h5,
		SXE_OP_TAB_SPEC = 4'h6,
		SXE_OP_TAB_CUR = 4'h7,
		SXE_OP_TAB_LAST = 4'h8,
		SXE_OP_XOR_ACC = 4'h9,
		SXE_OP_XOR_MEM = 4'hA,
		SXE_OP_XOR_IMM = 4'hB
	} sxe_op_t;
	// decoded instruction request
	typedef struct packed {
		sxe_op_t op;
		logic [`SXE_DADDR_W-1:0] addr;
		logic [`SXE_BIT_W-1:0] bit_sel;
		logic [`SXE_DATA_W-1:0] imm;
	} sxe_req_t;
	// data memory write port
	typedef struct packed {
		logic we;
		logic [`SXE_DADDR_W-1:0] addr;
		logic [`SXE_DATA_W-1:0] data;
	} sxe_dwr_t;
	// sequencer states, gray along the skip path
	typedef enum logic [1:0] {
		SXE_ST_RUN = 2'b00,
		SXE_ST_DUMMY = 2'b01
	} sxe_state_t;
endpackage : sxe_pkg
`default_nettype wire

// [hdl/sxe_exec.sv]
// Behaviour
// - swap memory byte nibbles in place, flags kept
// - swapped memory nibbles into accumulator, memory kept
// - skip next instruction when byte zero
// - taken skip inserts one dummy cycle
// - copy byte to accumulator, skip if zero
// - skip next instruction when selected bit zero
// - table read via both pointers, low/high split
// - table read in current page, low pointer
// - table read in last page, low pointer
// - accumulator xor memory into accumulator, zero flag
// - accumulator xor memory into memory, zero flag
// - accumulator xor immediate into accumulator, zero flag
`default_nettype none
`include "sxe_map.svh"
module sxe_exec
	import sxe_pkg::*;
(
	input wire logic clock,
	input wire logic rstn,
	input wire logic req_valid,
	output logic req_ready,
	input wire sxe_req_t req,
	input wire logic [`SXE_DATA_W-1:0] mem_rdata,
	input wire logic [`SXE_PROG_W-1:0] prog_rdata,
	input wire logic [`SXE_DATA_W-1:0] table_pointer_low,
	input wire logic [`SXE_DATA_W-1:0] table_pointer_high,
	input wire logic [`SXE_PAGE_W-1:0] current_page,
	output logic [`SXE_DADDR_W-1:0] mem_raddr,
	output logic [`SXE_PADDR_W-1:0] prog_addr,
	output sxe_dwr_t mem_wr,
	output logic [`SXE_DATA_W-1:0] acc,
	output logic zero_flag,
	output logic [`SXE_DATA_W-1:0] table_high_byte_latch,
	output logic skip_taken,
	output logic dummy_cycle
);
	// sequencer state
	sxe_state_t state_reg;
	sxe_state_t state_next;
	// results of the current instruction
	logic [`SXE_DATA_W-1:0] nib_swapped;
	logic [`SXE_DATA_W-1:0] xor_mem;
	logic [`SXE_DATA_W-1:0] xor_imm;
	logic byte_zero;
	logic bit_zero;
	logic skip_now;
	logic fire;
	logic tab_op;

	// memory and program addresses follow the request combinationally
	assign mem_raddr = req.addr;
	always_comb begin
		case (req.op)
			SXE_OP_TAB_CUR: begin
				prog_addr = {current_page, table_pointer_low};
			end
			SXE_OP_TAB_LAST: begin
				prog_addr = {`SXE_LAST_PAGE, table_pointer_low};
			end
			default: begin
				// specific page uses both pointers; top pointer bits beyond the space are dropped
				prog_addr = {table_pointer_high[`SXE_PAGE_W-1:0], table_pointer_low};
			end
		endcase
	end

	// specific page takes the page field from the high pointer, upper pointer bits ignored
	chk_spec_page_addr: assert property (@(posedge clock) disable iff (!rstn)
		(req.op == SXE_OP_TAB_SPEC) |->
		(prog_addr[`SXE_PADDR_W-1:`SXE_DATA_W] == table_pointer_high[`SXE_PAGE_W-1:0]
		&& prog_addr[`SXE_DATA_W-1:0] == table_pointer_low))
		else $error("specific page address wrong");
	// current page keeps the page field of the running program
	chk_cur_page_addr: assert property (@(posedge clock) disable iff (!rstn)
		(req.op == SXE_OP_TAB_CUR) |-> (prog_addr[`SXE_PADDR_W-1:`SXE_DATA_W] == current_page
		&& prog_addr[`SXE_DATA_W-1:0] == table_pointer_low))
		else $error("current page address wrong");
	// last page forces the top page whatever the high pointer holds
	chk_last_page_addr: assert property (@(posedge clock) disable iff (!rstn)
		(req.op == SXE_OP_TAB_LAST) |-> (prog_addr[`SXE_PADDR_W-1:`SXE_DATA_W] == `SXE_LAST_PAGE
		&& prog_addr[`SXE_DATA_W-1:0] == table_pointer_low))
		else $error("last page address wrong");

	// datapath helpers
	assign nib_swapped = {mem_rdata[`SXE_NIB_W-1:0], mem_rdata[`SXE_DATA_W-1:`SXE_NIB_W]};
	assign xor_mem = acc ^ mem_rdata;
	assign xor_imm = acc ^ req.imm;
	assign byte_zero = (mem_rdata == `SXE_ZERO_BYTE);
	assign bit_zero = ~mem_rdata[req.bit_sel];
	// no new instruction accepted while the dummy cycle runs
	assign req_ready = (state_reg == SXE_ST_RUN);
	assign fire = req_valid && req_ready;
	assign tab_op = (req.op == SXE_OP_TAB_SPEC) || (req.op == SXE_OP_TAB_CUR) || (req.op == SXE_OP_TAB_LAST);

	// skip decision
	always_comb begin
		case (req.op)
			SXE_OP_SKZ: begin
				skip_now = byte_zero;
			end
			SXE_OP_SKZ_MOVE: begin
				skip_now = byte_zero;
			end
			SXE_OP_SKZ_BIT: begin
				skip_now = bit_zero;
			end
			default: begin
				skip_now = 1'b0;
			end
		endcase
	end

	// sequencer: a taken skip holds off the next request one cycle
	always_comb begin
		case (state_reg)
			SXE_ST_RUN: begin
				state_next = (fire && skip_now) ? SXE_ST_DUMMY : SXE_ST_RUN;
			end
			SXE_ST_DUMMY: begin
				state_next = SXE_ST_RUN;
			end
			default: begin
				state_next = SXE_ST_RUN;
			end
		endcase
	end

	// state register
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			state_reg <= SXE_ST_RUN;
		end else begin
			state_reg <= state_next;
		end
	end

	// skip pulse and dummy marker, registered
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			skip_taken <= 1'b0;
			dummy_cycle <= 1'b0;
		end else begin
			skip_taken <= fire && skip_now;
			dummy_cycle <= (state_next == SXE_ST_DUMMY);
		end
	end

	// a taken skip must hold the decoder off for exactly one cycle
	chk_skip_blocks_next: assert property (@(posedge clock) disable iff (!rstn)
		(fire && skip_now) |=> (!req_ready ##1 req_ready))
		else $error("skip did not hold off exactly one cycle");
	// the dummy marker must cover exactly the refused cycle
	chk_dummy_marker: assert property (@(posedge clock) disable iff (!rstn)
		dummy_cycle == !req_ready)
		else $error("dummy marker out of step with ready");
	// byte test skips exactly when the byte is zero
	chk_zero_test_skip: assert property (@(posedge clock) disable iff (!rstn)
		(fire && req.op == SXE_OP_SKZ) |=> (skip_taken == ($past(mem_rdata) == `SXE_ZERO_BYTE)))
		else $error("byte zero test skip wrong");
	// the plain byte test leaves every register and flag alone
	chk_skz_no_change: assert property (@(posedge clock) disable iff (!rstn)
		(fire && req.op == SXE_OP_SKZ) |=> (!mem_wr.we && $stable(acc) && $stable(zero_flag)))
		else $error("byte zero test changed state");
	// bit test skips exactly when the selected bit is clear
	chk_bit_test_skip: assert property (@(posedge clock) disable iff (!rstn)
		(fire && req.op == SXE_OP_SKZ_BIT) |=> (skip_taken == !$past(mem_rdata[req.bit_sel])))
		else $error("bit zero test skip wrong");
	// the bit test leaves every register and flag alone
	chk_bit_no_change: assert property (@(posedge clock) disable iff (!rstn)
		(fire && req.op == SXE_OP_SKZ_BIT) |=> (!mem_wr.we && $stable(acc) && $stable(zero_flag)))
		else $error("bit zero test changed state");
	// only the three test forms may ever take a skip
	chk_no_stray_skip: assert property (@(posedge clock) disable iff (!rstn)
		(fire && req.op != SXE_OP_SKZ && req.op != SXE_OP_SKZ_MOVE && req.op != SXE_OP_SKZ_BIT) |=> !skip_taken)
		else $error("skip taken by a non test instruction");

	// accumulator: only the accumulator-writing operations touch it
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			acc <= `SXE_ACC_RST;
		end else if (fire) begin
			case (req.op)
				SXE_OP_SWAP_ACC: begin
					acc <= nib_swapped;
				end
				SXE_OP_SKZ_MOVE: begin
					acc <= mem_rdata;
				end
				SXE_OP_XOR_ACC: begin
					acc <= xor_mem;
				end
				SXE_OP_XOR_IMM: begin
					acc <= xor_imm;
				end
				default: begin
					acc <= acc;
				end
			endcase
		end
	end

	// move form copies the byte whatever the outcome, skipping on zero
	chk_move_to_acc: assert property (@(posedge clock) disable iff (!rstn)
		(fire && req.op == SXE_OP_SKZ_MOVE) |=> (acc == $past(mem_rdata)
		&& skip_taken == ($past(mem_rdata) == `SXE_ZERO_BYTE)))
		else $error("move with skip wrong");
	// move form leaves the zero flag and memory alone, even for a zero byte
	chk_move_no_flag: assert property (@(posedge clock) disable iff (!rstn)
		(fire && req.op == SXE_OP_SKZ_MOVE) |=> (!mem_wr.we && $stable(zero_flag)))
		else $error("move with skip touched flag or memory");
	// high memory nibble lands low in the accumulator and the other way round
	chk_swap_acc_value: assert property (@(posedge clock) disable iff (!rstn)
		(fire && req.op == SXE_OP_SWAP_ACC) |=>
		(acc[`SXE_NIB_W-1:0] == $past(mem_rdata[`SXE_DATA_W-1:`SXE_NIB_W])
		&& acc[`SXE_DATA_W-1:`SXE_NIB_W] == $past(mem_rdata[`SXE_NIB_W-1:0])
		&& !mem_wr.we && $stable(zero_flag)))
		else $error("nibble swap to accumulator wrong");
	// xor from memory updates the accumulator and the zero flag together
	chk_xor_acc_zero: assert property (@(posedge clock) disable iff (!rstn)
		(fire && req.op == SXE_OP_XOR_ACC) |=> (acc == ($past(acc) ^ $past(mem_rdata))
		&& zero_flag == (acc == `SXE_ZERO_BYTE)))
		else $error("xor to accumulator wrong");
	// xor immediate uses the operand carried in the instruction
	chk_xor_imm_zero: assert property (@(posedge clock) disable iff (!rstn)
		(fire && req.op == SXE_OP_XOR_IMM) |=> (acc == ($past(acc) ^ $past(req.imm))
		&& zero_flag == (acc == `SXE_ZERO_BYTE)))
		else $error("xor immediate wrong");
	// accumulator forms of xor must not write memory
	chk_xor_acc_no_write: assert property (@(posedge clock) disable iff (!rstn)
		(fire && (req.op == SXE_OP_XOR_ACC || req.op == SXE_OP_XOR_IMM)) |=> !mem_wr.we)
		else $error("accumulator xor wrote memory");

	// zero flag: only the xor group updates it, everything else leaves it
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			zero_flag <= 1'b0;
		end else if (fire) begin
			case (req.op)
				SXE_OP_XOR_ACC: begin
					zero_flag <= (xor_mem == `SXE_ZERO_BYTE);
				end
				SXE_OP_XOR_MEM: begin
					zero_flag <= (xor_mem == `SXE_ZERO_BYTE);
				end
				SXE_OP_XOR_IMM: begin
					zero_flag <= (xor_imm == `SXE_ZERO_BYTE);
				end
				default: begin
					zero_flag <= zero_flag;
				end
			endcase
		end
	end

	// data memory write port, registered one-cycle strobe
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			mem_wr <= '0;
		end else begin
			mem_wr.we <= 1'b0;
			mem_wr.addr <= req.addr;
			if (fire) begin
				case (req.op)
					SXE_OP_SWAP: begin
						mem_wr.we <= 1'b1;
						mem_wr.data <= nib_swapped;
					end
					SXE_OP_XOR_MEM: begin
						mem_wr.we <= 1'b1;
						mem_wr.data <= xor_mem;
					end
					SXE_OP_TAB_SPEC, SXE_OP_TAB_CUR, SXE_OP_TAB_LAST: begin
						mem_wr.we <= 1'b1;
						mem_wr.data <= prog_rdata[`SXE_DATA_W-1:0];
					end
					default: begin
						mem_wr.data <= mem_wr.data;
					end
				endcase
			end
		end
	end

	// in-place swap writes the exchanged nibbles back to the same byte
	chk_swap_mem_write: assert property (@(posedge clock) disable iff (!rstn)
		(fire && req.op == SXE_OP_SWAP) |=> (mem_wr.we && mem_wr.addr == $past(req.addr)
		&& mem_wr.data[`SXE_DATA_W-1:`SXE_NIB_W] == $past(mem_rdata[`SXE_NIB_W-1:0])
		&& mem_wr.data[`SXE_NIB_W-1:0] == $past(mem_rdata[`SXE_DATA_W-1:`SXE_NIB_W])
		&& $stable(acc) && $stable(zero_flag)))
		else $error("in place swap wrong");
	// xor to memory writes the result back and sets zero from it
	chk_xor_mem_write: assert property (@(posedge clock) disable iff (!rstn)
		(fire && req.op == SXE_OP_XOR_MEM) |=> (mem_wr.we && mem_wr.addr == $past(req.addr)
		&& mem_wr.data == ($past(acc) ^ $past(mem_rdata)) && zero_flag == (mem_wr.data == `SXE_ZERO_BYTE)))
		else $error("xor to memory wrong");
	// xor to memory leaves the accumulator as it was
	chk_xor_mem_acc_kept: assert property (@(posedge clock) disable iff (!rstn)
		(fire && req.op == SXE_OP_XOR_MEM) |=> $stable(acc))
		else $error("xor to memory changed the accumulator");

	// table high latch takes the upper byte of the code word
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			table_high_byte_latch <= `SXE_TABLE_HIGH_BYTE_LATCH_RST;
		end else if (fire && tab_op) begin
			table_high_byte_latch <= prog_rdata[`SXE_PROG_W-1:`SXE_DATA_W];
		end
	end

	// low byte to memory and high byte to the latch on the same edge
	chk_table_high_byte: assert property (@(posedge clock) disable iff (!rstn)
		(fire && tab_op) |=> (table_high_byte_latch == $past(prog_rdata[`SXE_PROG_W-1:`SXE_DATA_W])
		&& mem_wr.data == $past(prog_rdata[`SXE_DATA_W-1:0])))
		else $error("table read split wrong");
	// a table read writes the named byte and leaves accumulator and flag alone
	chk_table_mem_write: assert property (@(posedge clock) disable iff (!rstn)
		(fire && tab_op) |=> (mem_wr.we && mem_wr.addr == $past(req.addr) && $stable(acc) && $stable(zero_flag)))
		else $error("table read write or flag wrong");
endmodule : sxe_exec
`default_nettype wire

// [tb/test_cpu_swap_skip_table_xor_exec.sv]
`default_nettype none
`include "sxe_map.svh"
module test_cpu_swap_skip_table_xor_exec;
	timeunit 1ns;
	timeprecision 1ps;
	import sxe_pkg::*;
	logic clock = 1'b0; // core clock, 4 ns period
	logic rstn = 1'b0; // held low for the first 6 cycles
	logic req_valid = 1'b0;
	logic req_ready;
	sxe_req_t req = '0;
	logic [7:0] mem_rdata = 8'h00; // driven with the byte at mem_raddr
	logic [15:0] prog_rdata;
	logic [7:0] tpl = 8'h00;
	logic [7:0] tph = 8'h00;
	logic [4:0] cur_page = 5'h00;
	logic [7:0] mem_raddr;
	logic [12:0] prog_addr;
	sxe_dwr_t mem_wr;
	logic [7:0] acc;
	logic zero_flag;
	logic [7:0] latch;
	logic skip_taken;
	logic dummy_cycle;
	logic [12:0] pa_seen; // program address at the taking edge
	logic [7:0] ra_seen; // data memory address at the taking edge
	int bad_count = 0;
	int cmp_count = 0;
	// free running clock
	always #2 clock = ~clock;
	// program words differ in both bytes and per page so a swapped split or a wrong page shows up
	function automatic logic [15:0] rom(input logic [12:0] a);
		return {a[7:0] ^ {3'h0, a[12:8]}, 3'h5, a[12:8]};
	endfunction : rom
	// program memory answers in the same cycle
	assign prog_rdata = rom(prog_addr);
	sxe_exec sxe_exec_i (
		.clock(clock), .rstn(rstn), .req_valid(req_valid), .req_ready(req_ready), .req(req),
		.mem_rdata(mem_rdata), .prog_rdata(prog_rdata), .table_pointer_low(tpl),
		.table_pointer_high(tph), .current_page(cur_page), .mem_raddr(mem_raddr),
		.prog_addr(prog_addr), .mem_wr(mem_wr), .acc(acc), .zero_flag(zero_flag),
		.table_high_byte_latch(latch), .skip_taken(skip_taken), .dummy_cycle(dummy_cycle)
	);
	// verdict and end of run
	task report_and_stop;
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : report_and_stop
	// case equality so an unknown never matches
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// offer one instruction at a falling edge, hold it until taken; returns at the next falling edge
	task issue(input sxe_op_t op, input logic [7:0] a, input logic [2:0] b, input logic [7:0] i,
		input logic [7:0] m);
		int n;
		req = '{op, a, b, i};
		mem_rdata = m;
		req_valid = 1'b1;
		n = 0;
		while (req_ready !== 1'b1) begin
			@(negedge clock);
			n++;
			if (n > 8) begin
				bad_count++;
				report_and_stop();
			end
		end
		@(posedge clock);
		// addresses are combinational from inputs set at the falling edge, so they have settled here
		pa_seen = prog_addr;
		ra_seen = mem_raddr;
		@(negedge clock);
	endtask : issue
	// drop the request and let one edge pass
	task idle;
		req_valid = 1'b0;
		@(negedge clock);
	endtask : idle
	// xor forms, zero flag both ways
	task t_xor;
		issue(SXE_OP_XOR_IMM, 8'h10, 3'h0, 8'h3C, 8'h00);
		chk(acc, 8'h3C);
		chk(zero_flag, 1'b0);
		issue(SXE_OP_XOR_ACC, 8'h10, 3'h0, 8'h00, 8'hC3);
		chk(acc, 8'h3C ^ 8'hC3);
		chk(zero_flag, 1'b0);
		issue(SXE_OP_XOR_MEM, 8'h11, 3'h0, 8'h00, 8'hFF);
		chk(mem_wr, {1'b1, 8'h11, 8'hFF ^ 8'hFF});
		chk(zero_flag, 1'b1);
		chk(acc, 8'hFF);
		issue(SXE_OP_XOR_IMM, 8'h10, 3'h0, 8'hFF, 8'h00);
		chk(acc, 8'h00);
		chk(mem_wr.we, 1'b0);
		idle();
	endtask : t_xor
	// back to back swaps; zero flag left set by the xor run
	task t_swap;
		issue(SXE_OP_SWAP, 8'h21, 3'h0, 8'h00, 8'h5A);
		chk(mem_wr, {1'b1, 8'h21, 8'hA5});
		chk(zero_flag, 1'b1);
		chk(acc, 8'h00);
		chk(ra_seen, 8'h21);
		issue(SXE_OP_SWAP_ACC, 8'h22, 3'h0, 8'h00, 8'h96);
		chk(acc, 8'h69);
		chk(mem_wr.we, 1'b0);
		chk(zero_flag, 1'b1);
		chk(ra_seen, 8'h22);
		idle();
	endtask : t_swap
	// skips; a request held through the dummy cycle must wait
	task t_skip;
		issue(SXE_OP_SKZ, 8'h30, 3'h0, 8'h00, 8'h00);
		chk({skip_taken, dummy_cycle, req_ready}, 3'b110);
		req = '{SXE_OP_XOR_IMM, 8'h30, 3'h0, 8'h0F};
		@(negedge clock);
		chk(acc, 8'h69);
		chk({skip_taken, dummy_cycle, req_ready}, 3'b001);
		@(posedge clock);
		@(negedge clock);
		chk(acc, 8'h69 ^ 8'h0F);
		issue(SXE_OP_SKZ, 8'h31, 3'h0, 8'h00, 8'h01);
		chk(skip_taken, 1'b0);
		chk({mem_wr.we, zero_flag, acc}, {1'b0, 1'b0, 8'h66});
		issue(SXE_OP_SKZ_MOVE, 8'h32, 3'h0, 8'h00, 8'h00);
		chk({acc, skip_taken}, {8'h00, 1'b1});
		chk(zero_flag, 1'b0);
		issue(SXE_OP_SKZ_MOVE, 8'h33, 3'h0, 8'h00, 8'h7E);
		chk({acc, skip_taken}, {8'h7E, 1'b0});
		for (int i = 0; i < 8; i++) begin
			issue(SXE_OP_SKZ_BIT, 8'h34, 3'(i), 8'h00, ~(8'h01 << i));
			chk(skip_taken, 1'b1);
			issue(SXE_OP_SKZ_BIT, 8'h34, 3'(i), 8'h00, 8'h01 << i);
			chk(skip_taken, 1'b0);
		end
		idle();
	endtask : t_skip
	// three page forms; upper pointer bits above the page field must not leak in
	task t_table;
		sxe_op_t ops[3];
		logic [12:0] ea[3];
		logic [15:0] w;
		ops = '{SXE_OP_TAB_SPEC, SXE_OP_TAB_CUR, SXE_OP_TAB_LAST};
		tph = 8'hF3;
		tpl = 8'h4B;
		cur_page = 5'h0A;
		ea[0] = {5'h13, 8'h4B};
		ea[1] = {5'h0A, 8'h4B};
		ea[2] = {`SXE_LAST_PAGE, 8'h4B};
		for (int k = 0; k < 3; k++) begin
			w = rom(ea[k]);
			issue(ops[k], 8'h40 + 8'(k), 3'h0, 8'h00, 8'h00);
			chk(pa_seen, ea[k]);
			chk(mem_wr, {1'b1, 8'h40 + 8'(k), w[7:0]});
			chk(latch, w[15:8]);
		end
		idle();
	endtask : t_table
	// main sequence
	initial begin
		repeat (6) @(posedge clock);
		@(negedge clock);
		rstn = 1'b1;
		t_xor();
		t_swap();
		t_skip();
		t_table();
		report_and_stop();
	end
endmodule : test_cpu_swap_skip_table_xor_exec
`default_nettype wire
